// ---- shared/radio_bank_regs.svh ----
`ifndef RADIO_BANK_REGS_SVH
`define RADIO_BANK_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_SHUTDOWN   10'h322
`define IDX_RX_POWER   10'h324
`define IDX_AUX_MON    10'h325
`define IDX_CONV_HI    10'h327
`define IDX_CONV_LO    10'h328
`define IDX_TRIP       10'h32d
`define IDX_EXT_DIV    10'h32e
`define IDX_AGC_DIV    10'h32f
`define IDX_SRC_PKT    10'h336
`define IDX_SRC_SYS    10'h337

// Reset values
`define RST_ZERO       8'h00
`define RST_EXT_DIV    8'h04
`define RST_AGC_DIV    8'h28

// Writable bits of each register
`define MASK_SHUTDOWN  8'h01
`define MASK_RX_POWER  8'h1f
`define MASK_AUX_MON   8'h03
`define MASK_TRIP      8'h1f
`define MASK_EXT_DIV   8'h0f
`define MASK_AGC_DIV   8'hff
`define MASK_SRC_PKT   8'hff
`define MASK_SRC_SYS   8'hd3

// Field positions
`define POS_POWER_OFF_REQ   0
`define POS_CONV_PWR        4
`define POS_LEVEL_PWR       3
`define POS_FILTER_PWR      2
`define POS_MIXER_PWR       1
`define POS_LNA_PWR         0
`define POS_TEMP_MON        1
`define POS_SUPPLY_MON      0
`define POS_SRC_WAKE_COUNT  7
`define POS_SRC_SMART_WAKE  6
`define POS_SRC_AES_DONE    5
`define POS_SRC_TX_END      4
`define POS_SRC_ADDR_MATCH  3
`define POS_SRC_CRC_PASS    2
`define POS_SRC_SYNC        1
`define POS_SRC_PREAMBLE    0
`define POS_SRC_SUPPLY_LOW  7
`define POS_SRC_CMD_READY   6
`define POS_SRC_WAKE_TIMER  4
`define POS_SRC_SPI_READY   1
`define POS_SRC_CMD_DONE    0

// Gain clock prescale: divisor times 16
`define AGC_PRESCALE_BITS   4

// Bus answers
`define RESP_OKAY      2'b00
`define RESP_DECERR    2'b11

`endif

// ---- shared/radio_bank_pkg.sv ----
package radio_bank_pkg;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [11:0] axi_addr_t;
    typedef logic [31:0] axi_data_t;
    typedef logic [3:0]  axi_strb_t;
    typedef logic [1:0]  axi_resp_t;
    typedef logic [9:0]  reg_index_t;
endpackage : radio_bank_pkg

// ---- hw/radio_tick_divider.sv ----
`timescale 1ns/100ps
`default_nettype none
module radio_tick_divider #(
    parameter int W = 4
) (
    input  wire logic         CLK,
    input  wire logic         RESETN,
    input  wire logic         run,
    input  wire logic [W-1:0] divisor,
    output logic              tick
);
    logic [W-1:0] cnt_q;
    logic         tick_q;
    wire          idle = !run || (divisor == '0);
    wire          wrap = (cnt_q >= divisor - W'(1));

    // One tick every divisor cycles; zero divisor stops it
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (idle) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (wrap) begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + W'(1);
            tick_q <= 1'b0;
        end
    end

    assign tick = tick_q;
endmodule : radio_tick_divider
`default_nettype wire

// ---- hw/radio_power_aux_irq_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "radio_bank_regs.svh"
module radio_power_aux_irq_regs (
    input  wire logic                      CLK,
    input  wire logic                      RESETN,
    input  wire logic                      AWVALID,
    output logic                           AWREADY,
    input  wire radio_bank_pkg::axi_addr_t AWADDR,
    input  wire logic                      WVALID,
    output logic                           WREADY,
    input  wire radio_bank_pkg::axi_data_t WDATA,
    input  wire radio_bank_pkg::axi_strb_t WSTRB,
    output logic                           BVALID,
    input  wire logic                      BREADY,
    output radio_bank_pkg::axi_resp_t      BRESP,
    input  wire logic                      ARVALID,
    output logic                           ARREADY,
    input  wire radio_bank_pkg::axi_addr_t ARADDR,
    output logic                           RVALID,
    input  wire logic                      RREADY,
    output radio_bank_pkg::axi_data_t      RDATA,
    output radio_bank_pkg::axi_resp_t      RRESP,
    input  wire logic                      CHIP_SELECT,
    output logic                           POWER_OFF,
    output logic                           CONVERTER_POWER_ENABLE,
    output logic                           SIGNAL_STRENGTH_POWER_ENABLE,
    output logic                           IF_FILTER_POWER_ENABLE,
    output logic                           MIXER_POWER_ENABLE,
    output logic                           LOW_NOISE_AMP_POWER_ENABLE,
    output logic                           TEMPERATURE_MONITOR_ENABLE,
    output logic                           SUPPLY_MONITOR_ENABLE,
    output logic [4:0]                     SUPPLY_TRIP_CODE,
    input  wire logic                      SUPPLY_BELOW_TRIP,
    input  wire logic [7:0]                CONVERTER_RESULT,
    output logic                           CLOCK_OUTPUT_PIN,
    input  wire logic                      FSK_MODE,
    output logic                           GAIN_CLOCK_TICK,
    input  wire logic [15:0]               WAKE_EVENT_COUNT,
    input  wire logic [15:0]               WAKE_EVENT_LIMIT,
    input  wire logic                      SMART_WAKE_ACTIVE,
    input  wire logic [7:0]                SIGNAL_LEVEL,
    input  wire logic [7:0]                SMART_WAKE_LEVEL_LIMIT,
    input  wire logic                      CIPHER_LOADED,
    input  wire logic                      CIPHER_DONE,
    input  wire logic                      PACKET_MODE,
    input  wire logic                      TX_END,
    input  wire logic                      ADDRESS_MATCH,
    input  wire logic                      CRC_PASS,
    input  wire logic                      SYNC_FOUND,
    input  wire logic                      PREAMBLE_FOUND,
    input  wire logic                      CMD_READY,
    input  wire logic                      WAKE_TIMER_EXPIRED,
    input  wire logic                      SPI_READY,
    input  wire logic                      CMD_DONE
);
    import radio_bank_pkg::*;

    // Bus holding registers
    logic       aw_full_q;
    reg_index_t aw_idx_q;
    logic       w_full_q;
    reg_byte_t  w_byte_q;
    logic       w_lane_q;
    logic       bvalid_q;
    axi_resp_t  bresp_q;
    logic       rvalid_q;
    axi_data_t  rdata_q;
    axi_resp_t  rresp_q;
    // Bank registers
    reg_byte_t  shut_q;
    reg_byte_t  rx_q;
    reg_byte_t  aux_q;
    reg_byte_t  trip_q;
    reg_byte_t  ext_q;
    reg_byte_t  agc_q;
    reg_byte_t  src_pkt_q;
    reg_byte_t  src_sys_q;
    reg_byte_t  src_pkt_d;
    reg_byte_t  src_sys_d;
    // Pin synchronisers and registered power-off output
    logic       cs_s1_q;
    logic       cs_s2_q;
    logic       low_s1_q;
    logic       low_s2_q;
    logic       power_off_q;
    // Write channel
    wire aw_take = AWVALID && AWREADY;
    wire w_take  = WVALID && WREADY;
    wire wr_go   = aw_full_q && w_full_q && !bvalid_q;
    wire wr_en   = wr_go && w_lane_q;
    wire wh_shut = aw_idx_q == `IDX_SHUTDOWN;
    wire wh_rx   = aw_idx_q == `IDX_RX_POWER;
    wire wh_aux  = aw_idx_q == `IDX_AUX_MON;
    wire wh_chi  = aw_idx_q == `IDX_CONV_HI;
    wire wh_clo  = aw_idx_q == `IDX_CONV_LO;
    wire wh_trip = aw_idx_q == `IDX_TRIP;
    wire wh_ext  = aw_idx_q == `IDX_EXT_DIV;
    wire wh_agc  = aw_idx_q == `IDX_AGC_DIV;
    wire wh_spkt = aw_idx_q == `IDX_SRC_PKT;
    wire wh_ssys = aw_idx_q == `IDX_SRC_SYS;
    wire wh_any  = wh_shut | wh_rx | wh_aux | wh_chi | wh_clo | wh_trip |
                   wh_ext | wh_agc | wh_spkt | wh_ssys;

    assign AWREADY = !aw_full_q;
    assign WREADY  = !w_full_q;
    assign BVALID  = bvalid_q;
    assign BRESP   = bresp_q;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            aw_full_q <= 1'b0;
            aw_idx_q  <= '0;
        end else if (aw_take) begin
            aw_full_q <= 1'b1;
            aw_idx_q  <= AWADDR[11:2];
        end else if (wr_go) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            w_full_q <= 1'b0;
            w_byte_q <= '0;
            w_lane_q <= 1'b0;
        end else if (w_take) begin
            w_full_q <= 1'b1;
            w_byte_q <= WDATA[7:0];
            w_lane_q <= WSTRB[0];
        end else if (wr_go) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wh_any ? `RESP_OKAY : `RESP_DECERR;
        end else if (BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // Plain register writes, reserved bits dropped
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            shut_q <= `RST_ZERO;
            rx_q   <= `RST_ZERO;
            aux_q  <= `RST_ZERO;
            trip_q <= `RST_ZERO;
            ext_q  <= `RST_EXT_DIV;
            agc_q  <= `RST_AGC_DIV;
        end else if (wr_en) begin
            if (wh_shut) shut_q <= w_byte_q & `MASK_SHUTDOWN;
            if (wh_rx)   rx_q   <= w_byte_q & `MASK_RX_POWER;
            if (wh_aux)  aux_q  <= w_byte_q & `MASK_AUX_MON;
            if (wh_trip) trip_q <= w_byte_q & `MASK_TRIP;
            if (wh_ext)  ext_q  <= w_byte_q & `MASK_EXT_DIV;
            if (wh_agc)  agc_q  <= w_byte_q & `MASK_AGC_DIV;
        end
    end

    // Event sources, set wins over a write-one clear
    wire [7:0] clr_pkt = (wr_en && wh_spkt) ? w_byte_q : 8'h00;
    wire [7:0] clr_sys = (wr_en && wh_ssys) ? w_byte_q : 8'h00;
    wire [7:0] set_pkt;
    wire [7:0] set_sys;

    assign set_pkt[`POS_SRC_WAKE_COUNT] =
        WAKE_EVENT_COUNT == WAKE_EVENT_LIMIT;
    assign set_pkt[`POS_SRC_SMART_WAKE] =
        SMART_WAKE_ACTIVE && (SIGNAL_LEVEL > SMART_WAKE_LEVEL_LIMIT);
    assign set_pkt[`POS_SRC_AES_DONE]   = CIPHER_LOADED && CIPHER_DONE;
    assign set_pkt[`POS_SRC_TX_END]     = PACKET_MODE && TX_END;
    assign set_pkt[`POS_SRC_ADDR_MATCH] = PACKET_MODE && ADDRESS_MATCH;
    assign set_pkt[`POS_SRC_CRC_PASS]   = PACKET_MODE && CRC_PASS;
    assign set_pkt[`POS_SRC_SYNC]       = SYNC_FOUND;
    assign set_pkt[`POS_SRC_PREAMBLE]   = PREAMBLE_FOUND;
    assign set_sys[`POS_SRC_SUPPLY_LOW] =
        aux_q[`POS_SUPPLY_MON] && low_s2_q;
    assign set_sys[`POS_SRC_CMD_READY]  = CMD_READY;
    assign set_sys[5]                   = 1'b0;
    assign set_sys[`POS_SRC_WAKE_TIMER] = WAKE_TIMER_EXPIRED;
    assign set_sys[3:2]                 = 2'b00;
    assign set_sys[`POS_SRC_SPI_READY]  = SPI_READY;
    assign set_sys[`POS_SRC_CMD_DONE]   = CMD_DONE;
    assign src_pkt_d = (src_pkt_q & ~clr_pkt) | set_pkt;
    assign src_sys_d = ((src_sys_q & ~clr_sys) | set_sys)
                       & `MASK_SRC_SYS;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            src_pkt_q <= `RST_ZERO;
            src_sys_q <= `RST_ZERO;
        end else begin
            src_pkt_q <= src_pkt_d;
            src_sys_q <= src_sys_d;
        end
    end

    // Pin inputs through two flops
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cs_s1_q  <= 1'b0;
            cs_s2_q  <= 1'b0;
            low_s1_q <= 1'b0;
            low_s2_q <= 1'b0;
        end else begin
            cs_s1_q  <= CHIP_SELECT;
            cs_s2_q  <= cs_s1_q;
            low_s1_q <= SUPPLY_BELOW_TRIP;
            low_s2_q <= low_s1_q;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            power_off_q <= 1'b0;
        end else begin
            power_off_q <= shut_q[`POS_POWER_OFF_REQ] && cs_s2_q;
        end
    end

    assign POWER_OFF                    = power_off_q;
    assign CONVERTER_POWER_ENABLE       = rx_q[`POS_CONV_PWR];
    assign SIGNAL_STRENGTH_POWER_ENABLE = rx_q[`POS_LEVEL_PWR];
    assign IF_FILTER_POWER_ENABLE       = rx_q[`POS_FILTER_PWR];
    assign MIXER_POWER_ENABLE           = rx_q[`POS_MIXER_PWR];
    assign LOW_NOISE_AMP_POWER_ENABLE   = rx_q[`POS_LNA_PWR];
    assign TEMPERATURE_MONITOR_ENABLE   = aux_q[`POS_TEMP_MON];
    assign SUPPLY_MONITOR_ENABLE        = aux_q[`POS_SUPPLY_MON];
    assign SUPPLY_TRIP_CODE             = trip_q[4:0];
    // Clock dividers
    radio_tick_divider #(.W(4)) u_ext_div (
        .CLK     (CLK),
        .RESETN  (RESETN),
        .run     (1'b1),
        .divisor (ext_q[3:0]),
        .tick    (CLOCK_OUTPUT_PIN)
    );
    radio_tick_divider #(.W(8 + `AGC_PRESCALE_BITS)) u_agc_div (
        .CLK     (CLK),
        .RESETN  (RESETN),
        .run     (FSK_MODE),
        .divisor ({agc_q, {`AGC_PRESCALE_BITS{1'b0}}}),
        .tick    (GAIN_CLOCK_TICK)
    );

    // Read channel
    wire       ar_take = ARVALID && ARREADY;
    wire [9:0] ar_idx  = ARADDR[11:2];
    wire rh_shut = ar_idx == `IDX_SHUTDOWN;
    wire rh_rx   = ar_idx == `IDX_RX_POWER;
    wire rh_aux  = ar_idx == `IDX_AUX_MON;
    wire rh_chi  = ar_idx == `IDX_CONV_HI;
    wire rh_clo  = ar_idx == `IDX_CONV_LO;
    wire rh_trip = ar_idx == `IDX_TRIP;
    wire rh_ext  = ar_idx == `IDX_EXT_DIV;
    wire rh_agc  = ar_idx == `IDX_AGC_DIV;
    wire rh_spkt = ar_idx == `IDX_SRC_PKT;
    wire rh_ssys = ar_idx == `IDX_SRC_SYS;
    wire rh_any  = rh_shut | rh_rx | rh_aux | rh_chi | rh_clo | rh_trip |
                   rh_ext | rh_agc | rh_spkt | rh_ssys;
    wire [7:0] conv_hi = {2'b00, CONVERTER_RESULT[7:2]};
    wire [7:0] conv_lo = {CONVERTER_RESULT[1:0], 6'b000000};
    wire [7:0] rd_byte = ({8{rh_shut}} & shut_q)
                       | ({8{rh_rx}}   & rx_q)
                       | ({8{rh_aux}}  & aux_q)
                       | ({8{rh_chi}}  & conv_hi)
                       | ({8{rh_clo}}  & conv_lo)
                       | ({8{rh_trip}} & trip_q)
                       | ({8{rh_ext}}  & ext_q)
                       | ({8{rh_agc}}  & agc_q)
                       | ({8{rh_spkt}} & src_pkt_q)
                       | ({8{rh_ssys}} & src_sys_q);
    assign ARREADY = !rvalid_q;
    assign RVALID  = rvalid_q;
    assign RDATA   = rdata_q;
    assign RRESP   = rresp_q;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= `RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte};
            rresp_q  <= rh_any ? `RESP_OKAY : `RESP_DECERR;
        end else if (RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    chk_power_off_cause: assert property (
        POWER_OFF |-> $past(shut_q[`POS_POWER_OFF_REQ]) && $past(cs_s2_q))
        else $error("power off without request and chip select");
    chk_rx_enable_write: assert property (
        wr_en && wh_rx |=>
            CONVERTER_POWER_ENABLE == $past(w_byte_q[`POS_CONV_PWR]) &&
            LOW_NOISE_AMP_POWER_ENABLE == $past(w_byte_q[`POS_LNA_PWR]))
        else $error("receive enable does not follow write");
    chk_aux_enable_write: assert property (
        wr_en && wh_aux |=>
            TEMPERATURE_MONITOR_ENABLE == $past(w_byte_q[`POS_TEMP_MON]))
        else $error("temperature enable does not follow write");
    chk_result_split: assert property (
        ar_take && rh_chi |=>
            RVALID && RDATA[5:0] == $past(CONVERTER_RESULT[7:2]) &&
            RDATA[7:6] == 2'b00)
        else $error("converter upper read wrong");
    chk_supply_alarm: assert property (
        aux_q[`POS_SUPPLY_MON] && low_s2_q |=>
            src_sys_q[`POS_SRC_SUPPLY_LOW])
        else $error("low supply source not set");
    chk_ext_clock_off: assert property (
        ext_q[3:0] == 4'h0 |=> !CLOCK_OUTPUT_PIN)
        else $error("clock output runs with zero divisor");
    chk_gain_clock_idle: assert property (
        !FSK_MODE |=> !GAIN_CLOCK_TICK)
        else $error("gain clock ticks outside frequency shift mode");
    chk_packet_gate: assert property (
        !PACKET_MODE && !src_pkt_q[`POS_SRC_TX_END] |=>
            !src_pkt_q[`POS_SRC_TX_END])
        else $error("transmit end source set outside packet mode");
    chk_sources_sticky: assert property (
        1'b1 |=> (src_pkt_q & $past(src_pkt_q & ~clr_pkt)) ==
                 $past(src_pkt_q & ~clr_pkt))
        else $error("source bit dropped without clear");
    chk_reserved_zero: assert property (
        RVALID |-> RDATA[31:8] == 24'h000000 &&
                   (src_sys_q & ~`MASK_SRC_SYS) == 8'h00)
        else $error("reserved bits not zero");

    cov_write_done: cover property (wr_en ##1 BVALID && BREADY);
    cov_read_done:  cover property (ar_take ##1 RVALID && RREADY);
    cov_power_off:  cover property ($rose(POWER_OFF));
    cov_set_clear:  cover property (|(clr_pkt & set_pkt));
endmodule : radio_power_aux_irq_regs
`default_nettype wire

// ---- testbench/radio_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module radio_host_model
    import radio_bank_pkg::*;
(
    input  wire logic      CLK,
    output logic           AWVALID,
    input  wire logic      AWREADY,
    output axi_addr_t      AWADDR,
    output logic           WVALID,
    input  wire logic      WREADY,
    output axi_data_t      WDATA,
    output axi_strb_t      WSTRB,
    input  wire logic      BVALID,
    output logic           BREADY,
    output logic           ARVALID,
    input  wire logic      ARREADY,
    output axi_addr_t      ARADDR,
    input  wire logic      RVALID,
    output logic           RREADY,
    output logic           CHIP_SELECT
);
    initial begin
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, CHIP_SELECT} = '0;
        {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    end

    // Chip select is a plain level from the host
    task automatic set_cs(input logic v);
        @(posedge CLK);
        CHIP_SELECT <= v;
    endtask : set_cs

    task automatic wr_bus(input axi_addr_t a, input reg_byte_t d,
                          input axi_strb_t s);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge CLK);
        AWVALID <= 1'b1;
        AWADDR  <= a;
        WVALID  <= 1'b1;
        WDATA   <= {24'h000000, d};
        WSTRB   <= s;
        BREADY  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge CLK);
            if (AWVALID && AWREADY) begin
                aw_done = 1'b1;
                AWVALID <= 1'b0;
            end
            if (WVALID && WREADY) begin
                w_done = 1'b1;
                WVALID <= 1'b0;
            end
        end
        while (BVALID !== 1'b1) @(posedge CLK);
        BREADY <= 1'b0;
    endtask : wr_bus

    task automatic rd_bus(input axi_addr_t a);
        @(posedge CLK);
        ARVALID <= 1'b1;
        ARADDR  <= a;
        RREADY  <= 1'b1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge CLK); while (RVALID !== 1'b1);
        RREADY <= 1'b0;
    endtask : rd_bus
endmodule : radio_host_model
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "radio_bank_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin \
    n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
    import radio_bank_pkg::*;
    logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cs, pwr_off, gate, fsk;
    logic clk_out, gain_tick;
    logic [4:0] pwr, trip;
    logic [1:0] mon;
    axi_addr_t awaddr, araddr;
    axi_data_t wdata, rdata;
    axi_strb_t wstrb;
    axi_resp_t bresp, rresp;
    logic [15:0] ev, lim, e16;
    logic [7:0]  lvl, conv;
    logic [33:0] rq[$];
    axi_resp_t   bq[$];
    logic [33:0] exp_rd;
    axi_resp_t   exp_b;
    int n_errors = 0;
    int total_checks = 0;
    int c;
    reg_index_t idx [10] = '{`IDX_SHUTDOWN, `IDX_RX_POWER, `IDX_AUX_MON,
        `IDX_CONV_HI, `IDX_CONV_LO, `IDX_TRIP, `IDX_EXT_DIV, `IDX_AGC_DIV,
        `IDX_SRC_PKT, `IDX_SRC_SYS};
    reg_byte_t  msk [10] = '{`MASK_SHUTDOWN, `MASK_RX_POWER, `MASK_AUX_MON,
        8'h00, 8'h00, `MASK_TRIP, `MASK_EXT_DIV, `MASK_AGC_DIV, 8'h00, 8'h00};
    int ext_d [4] = '{0, 1, 3, 15};
    int agc_d [3] = '{1, 2, 0};

    initial clk = 1'b0;
    always #2 clk = ~clk;

    radio_host_model i_host (.CLK(clk), .AWVALID(awvalid), .AWREADY(awready),
        .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
        .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .ARVALID(arvalid),
        .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready),
        .CHIP_SELECT(cs));

    radio_power_aux_irq_regs i_dut (.CLK(clk), .RESETN(rst_n),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
        .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
        .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid),
        .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .CHIP_SELECT(cs),
        .POWER_OFF(pwr_off), .CONVERTER_POWER_ENABLE(pwr[4]),
        .SIGNAL_STRENGTH_POWER_ENABLE(pwr[3]),
        .IF_FILTER_POWER_ENABLE(pwr[2]), .MIXER_POWER_ENABLE(pwr[1]),
        .LOW_NOISE_AMP_POWER_ENABLE(pwr[0]),
        .TEMPERATURE_MONITOR_ENABLE(mon[1]), .SUPPLY_MONITOR_ENABLE(mon[0]),
        .SUPPLY_TRIP_CODE(trip), .SUPPLY_BELOW_TRIP(ev[15]),
        .CONVERTER_RESULT(conv), .CLOCK_OUTPUT_PIN(clk_out),
        .FSK_MODE(fsk), .GAIN_CLOCK_TICK(gain_tick),
        .WAKE_EVENT_COUNT(ev[7] ? lim : lim + 16'h0001),
        .WAKE_EVENT_LIMIT(lim), .SMART_WAKE_ACTIVE(gate),
        .SIGNAL_LEVEL(ev[6] ? lvl + 8'h01 : lvl),
        .SMART_WAKE_LEVEL_LIMIT(lvl), .CIPHER_LOADED(gate),
        .CIPHER_DONE(ev[5]), .PACKET_MODE(gate), .TX_END(ev[4]),
        .ADDRESS_MATCH(ev[3]), .CRC_PASS(ev[2]), .SYNC_FOUND(ev[1]),
        .PREAMBLE_FOUND(ev[0]), .CMD_READY(ev[14]),
        .WAKE_TIMER_EXPIRED(ev[12]), .SPI_READY(ev[9]), .CMD_DONE(ev[8]));

    // Scoreboard: oldest note against each answer
    always @(posedge clk) begin
        if (rvalid && rready) begin
            exp_rd = rq.pop_front();
            `CHK("read", exp_rd, {rresp, rdata})
        end
        if (bvalid && bready) begin
            exp_b = bq.pop_front();
            `CHK("bresp", exp_b, bresp)
        end
    end

    task automatic wr(input reg_index_t i, input reg_byte_t d,
                      input axi_strb_t s, input axi_resp_t r);
        bq.push_back(r);
        i_host.wr_bus({i, 2'b00}, d, s);
    endtask : wr

    task automatic rd(input reg_index_t i, input reg_byte_t d,
                      input axi_resp_t r);
        rq.push_back({r, 24'h000000, d});
        i_host.rd_bus({i, 2'b00});
    endtask : rd

    task automatic pulses(input logic sel, input int n, output int k);
        logic t;
        k = 0;
        repeat (n) begin
            @(posedge clk);
            t = sel ? gain_tick : clk_out;
            `CHK("tick_known", 1'b1, (t === 1'b0 || t === 1'b1))
            k += int'(t === 1'b1);
        end
    endtask : pulses

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        complete_run;
    end

    initial begin
        {rst_n, gate, fsk, ev, lim, lvl, conv} = '0;
        void'($urandom(32'h3f3d));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 10; k++)
            rd(idx[k], (k == 6) ? `RST_EXT_DIV : (k == 7) ? `RST_AGC_DIV
                : `RST_ZERO, `RESP_OKAY);
        rd(10'h323, 8'h00, `RESP_DECERR);
        $display("test reset values done");
        for (int k = 0; k < 8; k++) begin
            e16 = 16'($urandom);
            wr(idx[k], e16[7:0], 4'h1, `RESP_OKAY);
            rd(idx[k], e16[7:0] & msk[k], `RESP_OKAY);
        end
        wr(idx[1], 8'h15, 4'h1, `RESP_OKAY);
        wr(idx[2], 8'h01, 4'h1, `RESP_OKAY);
        wr(idx[5], 8'h0a, 4'h1, `RESP_OKAY);
        wr(idx[5], 8'h1f, 4'h0, `RESP_OKAY);
        wr(10'h323, 8'hff, 4'h1, `RESP_DECERR);
        `CHK("rx_pwr", 5'h15, pwr)
        `CHK("aux_mon", 2'b01, mon)
        `CHK("trip", 5'h0a, trip)
        $display("test rw registers done");
        conv <= 8'($urandom);
        @(posedge clk);
        rd(idx[3], {2'b00, conv[7:2]}, `RESP_OKAY);
        rd(idx[4], {conv[1:0], 6'h00}, `RESP_OKAY);
        $display("test converter done");
        wr(idx[0], 8'h01, 4'h1, `RESP_OKAY);
        repeat (5) @(posedge clk);
        `CHK("pwr_off_cs_low", 1'b0, pwr_off)
        i_host.set_cs(1'b1);
        repeat (5) @(posedge clk);
        `CHK("pwr_off_cs_high", 1'b1, pwr_off)
        wr(idx[0], 8'h00, 4'h1, `RESP_OKAY);
        repeat (3) @(posedge clk);
        `CHK("pwr_off_clear", 1'b0, pwr_off)
        i_host.set_cs(1'b0);
        $display("test shutdown done");
        lim <= 16'($urandom);
        lvl <= 8'($urandom_range(0, 254));
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 16; i++)
                if (!((16'h2c00 >> i) & 1)) begin
                    gate <= p[0];
                    ev   <= 16'h0001 << i;
                    repeat (4) @(posedge clk);
                    ev   <= 16'h0000;
                    repeat (4) @(posedge clk);
                    e16 = (p == 0 && ((16'h007c >> i) & 1)) ? 16'h0 :
                          16'h0001 << i;
                    rd(idx[8], e16[7:0], `RESP_OKAY);
                    rd(idx[9], e16[15:8], `RESP_OKAY);
                    wr(idx[8], 8'hff, 4'h1, `RESP_OKAY);
                    wr(idx[9], 8'hff, 4'h1, `RESP_OKAY);
                    rd(idx[8], 8'h00, `RESP_OKAY);
                    rd(idx[9], 8'h00, `RESP_OKAY);
                end
        $display("test event sources done");
        foreach (ext_d[k]) begin
            wr(idx[6], 8'(ext_d[k]), 4'h1, `RESP_OKAY);
            pulses(1'b0, 60, c);
            e16 = (ext_d[k] == 0) ? 16'd0 : 16'(60 / ext_d[k]);
            `CHK("ext_clk", 1'b1, (c + 1 >= e16 && c <= e16 + 1))
        end
        fsk <= 1'b1;
        foreach (agc_d[k]) begin
            wr(idx[7], 8'(agc_d[k]), 4'h1, `RESP_OKAY);
            pulses(1'b1, 320, c);
            e16 = (agc_d[k] == 0) ? 16'd0 : 16'(20 / agc_d[k]);
            `CHK("gain_clk", 1'b1, (c + 1 >= e16 && c <= e16 + 1))
        end
        fsk <= 1'b0;
        wr(idx[7], 8'h01, 4'h1, `RESP_OKAY);
        pulses(1'b1, 64, c);
        `CHK("gain_off", 0, c)
        $display("test dividers done");
        complete_run;
    end
endmodule : testbench
`default_nettype wire
